// ### common/root_port_pkg.sv
// Constants and carrier types of the root port link and slot register bank
package root_port_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_LINK_STATUS = 10'h07e;
  localparam logic [9:0] IDX_SLOT_CAP    = 10'h080;
  localparam logic [9:0] IDX_SLOT_CTRL   = 10'h084;
  localparam logic [9:0] IDX_SLOT_STATUS = 10'h086;
  localparam logic [11:0] ADDR_LINK_STATUS = {IDX_LINK_STATUS, 2'b00};
  localparam logic [11:0] ADDR_SLOT_CAP    = {IDX_SLOT_CAP, 2'b00};
  localparam logic [11:0] ADDR_SLOT_CTRL   = {IDX_SLOT_CTRL, 2'b00};
  localparam logic [11:0] ADDR_SLOT_STATUS = {IDX_SLOT_STATUS, 2'b00};
  // Link status fields
  localparam int LS_LINK_ACTIVE = 13;
  localparam int LS_SHARED_CLK  = 12;
  localparam int LS_TRAINING    = 11;
  localparam int LS_FAULT       = 10;
  localparam int LS_WIDTH_LO    = 4;
  localparam int LS_SPEED_LO    = 0;
  localparam logic       SHARED_CLK_RESET = 1'b1;
  localparam logic [5:0] WIDTH_X1   = 6'h01;
  localparam logic [5:0] WIDTH_X2   = 6'h02;
  localparam logic [5:0] WIDTH_X4   = 6'h04;
  localparam logic [5:0] WIDTH_X8   = 6'h08;
  localparam logic [5:0] WIDTH_NONE = 6'h00;
  localparam logic [3:0] SPEED_2G5  = 4'h1;
  // Slot capability fields
  localparam int CAP_SLOT_NUM_LO = 19;
  localparam int CAP_NO_CMD_DONE = 18;
  localparam int CAP_INTERLOCK   = 17;
  localparam int CAP_SCALE_LO    = 15;
  localparam int CAP_VALUE_LO    = 7;
  localparam int CAP_FLAGS_W     = 7;
  // Slot control fields
  localparam int CTL_LINK_CHG_EN = 12;
  localparam int CTL_POWER_OFF   = 10;
  localparam int CTL_PWR_IND_LO  = 8;
  localparam int CTL_ATN_IND_LO  = 6;
  localparam int CTL_MASTER_EN   = 5;
  localparam int CTL_CMD_DONE_EN = 4;
  localparam int CTL_PRES_EN     = 3;
  localparam int CTL_LOW_EN_W    = 3;
  localparam logic [1:0] IND_ON    = 2'b01;
  localparam logic [1:0] IND_BLINK = 2'b10;
  localparam logic [1:0] IND_OFF   = 2'b11;
  // Slot status fields
  localparam int ST_LINK_CHG  = 8;
  localparam int ST_CMD_DONE  = 4;
  localparam int ST_PRES_CHG  = 3;
  // Blink timing
  localparam longint CLK_HZ         = 64'd100000000;
  localparam longint BLINK_MILLI_HZ = 64'd1500;
  localparam longint BLINK_HALF_CYCLES = (CLK_HZ * 64'd1000) / (64'd2 * BLINK_MILLI_HZ);
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

  typedef struct packed {
    logic       dl_active;
    logic       in_detect;
    logic       in_config;
    logic       in_recovery;
    logic       in_l0;
    logic       train_error;
    logic       x8_slave;
    logic [5:0] width;
  } link_state_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] code;
  } ind_msg_s;
endpackage

// ### rtl/blink_divider.sv
// Free-running divider that makes the indicator blink square wave
`timescale 1ns/1ps
module blink_divider #(
  parameter longint HALF_CYCLES = root_port_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      blink
);
  localparam int CW = $clog2(HALF_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);
  logic [CW-1:0] count;

  generate
    if (HALF_CYCLES < 2) begin : g_bad
      $error("blink half period too short");
    end
  endgenerate

  // Equal halves: toggle every HALF_CYCLES cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      blink <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      blink <= ~blink;
    end else begin
      count <= count + 1'b1;
    end
  end

  half_equal_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(blink) |-> count == '0) else $error("blink edge off the count wrap");
endmodule

// ### rtl/link_slot_regs.sv
// Root port link status, slot capability and slot control register bank
`timescale 1ns/1ps
module link_slot_regs #(
  parameter int     PORT_NUM    = 1,
  parameter longint BLINK_HALF  = root_port_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic [31:0]                     hrdata,
  output logic                            hresp,
  input  wire root_port_pkg::link_state_s link_state,
  input  wire logic                       retrain_request,
  input  wire logic                       presence_change,
  input  wire logic                       legacy_card,
  output logic                            slot_power_off,
  output root_port_pkg::ind_msg_s         power_ind_msg,
  output root_port_pkg::ind_msg_s         attn_ind_msg,
  output logic                            vpin_power_ind,
  output logic                            vpin_attn_ind,
  output logic                            cmd_strobe,
  output logic                            hotplug_irq
);
  localparam logic X8_OK = (PORT_NUM == 2) || (PORT_NUM == 4) || (PORT_NUM == 6);

  generate
    if (PORT_NUM < 0 || PORT_NUM > 7) begin : g_bad
      $error("PORT_NUM must be 0 to 7");
    end
  endgenerate

  // Bus pipeline state
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic        req;
  logic [31:0] rd_word;

  // Link status state
  logic       shared_refclk_flag;
  logic       refclk_locked;
  logic       retrain_pending;
  logic       left_detect;
  logic       training_fault;
  logic [5:0] negotiated_width;
  logic       training_active;
  logic       l0_prev;
  logic       dl_prev;

  // Slot capability state
  logic                                 cap_locked;
  logic [12:0]                          physical_slot_number;
  logic [1:0]                           slot_power_scale;
  logic [7:0]                           slot_power_value;
  logic [root_port_pkg::CAP_FLAGS_W-1:0] cap_flags;

  // Slot control and status state
  logic                                   link_active_change_enable;
  logic                                   slot_power_control;
  logic [1:0]                             power_indicator_control;
  logic [1:0]                             attention_indicator_control;
  logic                                   hotplug_master_enable;
  logic                                   cmd_done_irq_enable;
  logic                                   presence_change_irq_enable;
  logic [root_port_pkg::CTL_LOW_EN_W-1:0] low_irq_enables;
  logic                                   cmd_done_status;
  logic                                   presence_status;
  logic                                   link_change_status;

  // Legacy card pin synchroniser
  logic legacy_meta;
  logic legacy_sync;
  logic blink;

  logic [31:0] link_word;
  logic [31:0] cap_word;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic        wr_link;
  logic        wr_cap;
  logic        wr_ctrl;
  logic        wr_status;
  logic        cmd_changed;
  logic [1:0]  next_pwr_ind;
  logic [1:0]  next_atn_ind;
  logic        in_training;

  blink_divider #(
    .HALF_CYCLES (BLINK_HALF)
  ) u_blink (
    .hclk    (hclk),
    .hresetn (hresetn),
    .blink   (blink)
  );

  // Bus slave: always zero wait, every response OKAY
  assign req       = hsel && hready && (htrans == root_port_pkg::HTRANS_NONSEQ ||
                                        htrans == root_port_pkg::HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_link   = wr_pend && wr_addr == root_port_pkg::ADDR_LINK_STATUS;
  assign wr_cap    = wr_pend && wr_addr == root_port_pkg::ADDR_SLOT_CAP;
  assign wr_ctrl   = wr_pend && wr_addr == root_port_pkg::ADDR_SLOT_CTRL;
  assign wr_status = wr_pend && wr_addr == root_port_pkg::ADDR_SLOT_STATUS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= req && hwrite && hsize == root_port_pkg::HSIZE_WORD;
      wr_addr <= {haddr[11:2], 2'b00};
    end
  end

  // Read word is sampled in the address phase, so a read right behind a write misses that write
  always_comb begin
    if (haddr[11:0] == root_port_pkg::ADDR_LINK_STATUS) begin
      rd_word = link_word;
    end else if (haddr[11:0] == root_port_pkg::ADDR_SLOT_CAP) begin
      rd_word = cap_word;
    end else if (haddr[11:0] == root_port_pkg::ADDR_SLOT_CTRL) begin
      rd_word = ctrl_word;
    end else if (haddr[11:0] == root_port_pkg::ADDR_SLOT_STATUS) begin
      rd_word = status_word;
    end else begin
      rd_word = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (req && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // Link status register
  assign in_training     = link_state.in_config || link_state.in_recovery;
  assign training_active = in_training || retrain_pending;
  assign link_word = {16'h0000,
                      2'b00,
                      link_state.dl_active,
                      shared_refclk_flag,
                      training_active,
                      training_fault,
                      negotiated_width,
                      root_port_pkg::SPEED_2G5};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shared_refclk_flag <= root_port_pkg::SHARED_CLK_RESET;
      refclk_locked      <= 1'b0;
    end else if (wr_link && !refclk_locked) begin
      shared_refclk_flag <= hwdata[root_port_pkg::LS_SHARED_CLK];
      refclk_locked      <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retrain_pending <= 1'b0;
    end else if (retrain_request) begin
      retrain_pending <= 1'b1;
    end else if (in_training) begin
      retrain_pending <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_detect <= 1'b0;
    end else if (in_training) begin
      left_detect <= 1'b1;
    end else if (link_state.in_detect) begin
      left_detect <= 1'b0;
    end
  end

  // A fault report in the L0 cycle still wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      training_fault <= 1'b0;
    end else if (link_state.train_error && ((left_detect && !link_state.in_detect) || in_training)) begin
      training_fault <= 1'b1;
    end else if (link_state.in_l0) begin
      training_fault <= 1'b0;
    end
  end

  // Width captured when training reaches L0; codes the port cannot reach are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      negotiated_width <= root_port_pkg::WIDTH_X4;
      l0_prev          <= 1'b0;
    end else begin
      l0_prev <= link_state.in_l0;
      if (link_state.in_l0 && !l0_prev) begin
        if (link_state.x8_slave) begin
          negotiated_width <= root_port_pkg::WIDTH_NONE;
        end else if (link_state.width == root_port_pkg::WIDTH_X1 ||
                     link_state.width == root_port_pkg::WIDTH_X2 ||
                     link_state.width == root_port_pkg::WIDTH_X4 ||
                     (X8_OK && link_state.width == root_port_pkg::WIDTH_X8)) begin
          negotiated_width <= link_state.width;
        end
      end
    end
  end

  // Slot capability: the first write locks the whole register
  assign cap_word = {physical_slot_number,
                     1'b0,
                     1'b0,
                     slot_power_scale,
                     slot_power_value,
                     cap_flags};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_locked           <= 1'b0;
      physical_slot_number <= '0;
      slot_power_scale     <= '0;
      slot_power_value     <= '0;
      cap_flags            <= '0;
    end else if (wr_cap && !cap_locked) begin
      cap_locked           <= 1'b1;
      physical_slot_number <= hwdata[31:root_port_pkg::CAP_SLOT_NUM_LO];
      slot_power_scale     <= hwdata[root_port_pkg::CAP_SCALE_LO+:2];
      slot_power_value     <= hwdata[root_port_pkg::CAP_VALUE_LO+:8];
      cap_flags            <= hwdata[root_port_pkg::CAP_FLAGS_W-1:0];
    end
  end

  // Slot control: each write is one command
  assign ctrl_word = {13'h0000,
                      1'b0,
                      5'h00,
                      link_active_change_enable,
                      1'b0,
                      slot_power_control,
                      power_indicator_control,
                      attention_indicator_control,
                      hotplug_master_enable,
                      cmd_done_irq_enable,
                      presence_change_irq_enable,
                      low_irq_enables};

  assign next_pwr_ind = hwdata[root_port_pkg::CTL_PWR_IND_LO+:2];
  assign next_atn_ind = hwdata[root_port_pkg::CTL_ATN_IND_LO+:2];
  assign cmd_changed  = wr_ctrl &&
                        (hwdata[root_port_pkg::CTL_POWER_OFF] != slot_power_control ||
                         next_pwr_ind != power_indicator_control ||
                         next_atn_ind != attention_indicator_control);
  assign cmd_strobe   = wr_ctrl;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_active_change_enable   <= 1'b0;
      slot_power_control          <= 1'b0;
      power_indicator_control     <= root_port_pkg::IND_OFF;
      attention_indicator_control <= root_port_pkg::IND_OFF;
      hotplug_master_enable       <= 1'b0;
      cmd_done_irq_enable         <= 1'b0;
      presence_change_irq_enable  <= 1'b0;
      low_irq_enables             <= '0;
    end else if (wr_ctrl) begin
      link_active_change_enable   <= hwdata[root_port_pkg::CTL_LINK_CHG_EN];
      slot_power_control          <= hwdata[root_port_pkg::CTL_POWER_OFF];
      power_indicator_control     <= next_pwr_ind;
      attention_indicator_control <= next_atn_ind;
      hotplug_master_enable       <= hwdata[root_port_pkg::CTL_MASTER_EN];
      cmd_done_irq_enable         <= hwdata[root_port_pkg::CTL_CMD_DONE_EN];
      presence_change_irq_enable  <= hwdata[root_port_pkg::CTL_PRES_EN];
      low_irq_enables             <= hwdata[root_port_pkg::CTL_LOW_EN_W-1:0];
    end
  end

  // Indicator messages go out one cycle wide, only for a field whose value changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_ind_msg <= '0;
      attn_ind_msg  <= '0;
    end else begin
      power_ind_msg.valid <= wr_ctrl && next_pwr_ind != power_indicator_control;
      power_ind_msg.code  <= next_pwr_ind;
      attn_ind_msg.valid  <= wr_ctrl && next_atn_ind != attention_indicator_control;
      attn_ind_msg.code   <= next_atn_ind;
    end
  end

  // Slot status: hardware set wins over a write-one clear in the same cycle
  assign status_word = {23'h000000,
                        link_change_status,
                        3'b000,
                        cmd_done_status,
                        presence_status,
                        3'b000};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_done_status <= 1'b0;
    end else if (cmd_changed) begin
      cmd_done_status <= 1'b1;
    end else if (wr_status && hwdata[root_port_pkg::ST_CMD_DONE]) begin
      cmd_done_status <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presence_status <= 1'b0;
    end else if (presence_change) begin
      presence_status <= 1'b1;
    end else if (wr_status && hwdata[root_port_pkg::ST_PRES_CHG]) begin
      presence_status <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dl_prev            <= 1'b0;
      link_change_status <= 1'b0;
    end else begin
      dl_prev <= link_state.dl_active;
      if (link_state.dl_active != dl_prev) begin
        link_change_status <= 1'b1;
      end else if (wr_status && hwdata[root_port_pkg::ST_LINK_CHG]) begin
        link_change_status <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hotplug_irq <= 1'b0;
    end else begin
      hotplug_irq <= hotplug_master_enable &&
                     ((cmd_done_status && cmd_done_irq_enable) ||
                      (presence_status && presence_change_irq_enable) ||
                      (link_change_status && link_active_change_enable));
    end
  end

  // Legacy card strap comes from a pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      legacy_meta <= 1'b0;
      legacy_sync <= 1'b0;
    end else begin
      legacy_meta <= legacy_card;
      legacy_sync <= legacy_meta;
    end
  end

  // Virtual pins driven only for legacy cards; reserved code 00 shows dark
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vpin_power_ind <= 1'b0;
      vpin_attn_ind  <= 1'b0;
      slot_power_off <= 1'b0;
    end else begin
      slot_power_off <= slot_power_control;
      vpin_power_ind <= legacy_sync && (power_indicator_control == root_port_pkg::IND_ON ||
                        (power_indicator_control == root_port_pkg::IND_BLINK && blink));
      vpin_attn_ind  <= legacy_sync && (attention_indicator_control == root_port_pkg::IND_ON ||
                        (attention_indicator_control == root_port_pkg::IND_BLINK && blink));
    end
  end

  dl_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    link_word[root_port_pkg::LS_LINK_ACTIVE] == link_state.dl_active) else $error("link active flag wrong");
  refclk_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(refclk_locked) && $past(wr_link) |-> $stable(shared_refclk_flag)) else $error("refclk flag rewritten");
  retrain_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    retrain_request ##1 !in_training |-> training_active) else $error("retrain not shown as training");
  fault_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(training_fault) |-> $past(!link_state.in_detect) && $past(left_detect || in_training))
    else $error("fault set before leaving detect");
  fault_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    link_state.in_l0 && !link_state.train_error |=> !training_fault) else $error("fault not cleared at L0");
  slave_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
    link_state.in_l0 && !l0_prev && link_state.x8_slave |=> negotiated_width == 6'h00) else $error("slave width");
  speed_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req && !hwrite && haddr[11:0] == root_port_pkg::ADDR_LINK_STATUS |=> hrdata[3:0] == 4'h1)
    else $error("speed code wrong");
  cap_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_locked && wr_cap |=> $stable(cap_word)) else $error("capability rewritten");
  cmd_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_changed |=> cmd_done_status ##1 (cmd_done_status || $past(wr_status))) else $error("no command done");
  no_change_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !cmd_changed && !cmd_done_status |=> !cmd_done_status) else $error("spurious command done");
  msg_sent_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && next_pwr_ind != power_indicator_control |=> power_ind_msg.valid && power_ind_msg.code == $past(next_pwr_ind))
    else $error("power indicator message missing");
  irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !hotplug_master_enable |=> !hotplug_irq) else $error("interrupt without master enable");
endmodule

// ### tb/link_model.sv
// Behavioural downstream link that trains on request
`timescale 1ns/1ps
module link_model (
  input  wire logic                  hclk,
  input  wire logic                  train,
  input  wire logic [5:0]            width,
  output root_port_pkg::link_state_s ls
);
  logic [2:0] ph = 3'h0;
  // Detect, two cycles of configuration, then L0 with the link up and held there
  always_ff @(posedge hclk) begin
    ph <= train ? 3'h1 : (ph != 3'h0 && ph != 3'h4) ? ph + 3'h1 : ph;
  end
  // Width is held steady before L0 entry so the port latches a settled code
  assign ls = '{dl_active: ph == 3'h4, in_detect: ph == 3'h1, in_config: ph inside {3'h2, 3'h3},
                in_recovery: 1'b0, in_l0: ph == 3'h4, train_error: ph inside {3'h1, 3'h3}, x8_slave: 1'b0,
                width: width};
endmodule

// ### tb/link_slot_regs_tb.sv
// Self-checking bench of the link and slot register bank
`timescale 1ns/1ps
module link_slot_regs_tb;
  logic                       hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, retrain = 1'b0, train = 1'b0, pres = 1'b0;
  logic [31:0]                haddr = 32'h0, hwdata = 32'h0, hrdata, r, ns = 32'h0;
  logic [1:0]                 htrans = 2'b00;
  logic [5:0]                 width = 6'h04;
  logic                       hreadyout, hresp, power_off, vpin_p, vpin_a, strobe, irq;
  root_port_pkg::link_state_s ls;
  root_port_pkg::ind_msg_s    pmsg, amsg;
  int                         n_fail = 0, checked = 0, cyc = 0;
  // Rows: address and the value it reads after reset; the last is unmapped
  logic [11:0] ra [5] = '{root_port_pkg::ADDR_LINK_STATUS, root_port_pkg::ADDR_SLOT_CAP,
                          root_port_pkg::ADDR_SLOT_CTRL, root_port_pkg::ADDR_SLOT_STATUS, 12'h3fc};
  logic [31:0] re [5] = '{32'h1041, 32'h0, 32'h3c0, 32'h0, 32'h0};
  initial forever #5 hclk = ~hclk;
  link_model u_link (.hclk(hclk), .train(train), .width(width), .ls(ls));
  link_slot_regs #(.BLINK_HALF(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(root_port_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_state(ls), .retrain_request(retrain),
    .presence_change(pres), .legacy_card(1'b1), .slot_power_off(power_off), .power_ind_msg(pmsg),
    .attn_ind_msg(amsg), .vpin_power_ind(vpin_p), .vpin_attn_ind(vpin_a), .cmd_strobe(strobe),
    .hotplug_irq(irq));
  // Strobe counted on the falling edge, where it is settled
  always @(negedge hclk) ns <= ns + {31'h0, strobe};
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Ceiling well above the fewer than a hundred cycles the tests take
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(r, re[i]);
    end
    $display("reset values done");
    bus(1'b1, ra[1], 32'h0007ffff); // On-board slot keeps slot number zero
    bus(1'b1, ra[1], 32'h0);
    bus(1'b0, ra[1], 32'h0);
    chk(r, 32'h0001ffff);
    bus(1'b1, ra[0], 32'h0); // Firmware clears the shared clock flag once
    bus(1'b1, ra[0], 32'h1000);
    bus(1'b0, ra[0], 32'h0);
    chk(r, 32'h41);
    $display("write once done");
    bus(1'b1, ra[2], 32'h1f0);
    #1 chk({29'h0, pmsg}, {29'h0, 1'b1, root_port_pkg::IND_ON});
    chk({31'h0, amsg.valid}, 32'h0);
    @(posedge hclk);
    bus(1'b0, ra[3], 32'h0);
    chk(r, 32'h10);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, ra[3], 32'h10); // Software acknowledges the completion
    bus(1'b1, ra[2], 32'h1f0);
    bus(1'b0, ra[3], 32'h0);
    chk(r, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, ra[2], 32'h6d0);
    bus(1'b0, ra[3], 32'h0);
    chk(r, 32'h10);
    chk({30'h0, irq, power_off}, 32'h1);
    chk(ns, 32'h3);
    pres <= 1'b1;
    @(posedge hclk);
    pres <= 1'b0;
    bus(1'b1, ra[2], 32'h6e8); // Same power and indicators, master and presence enables on
    bus(1'b0, ra[3], 32'h0);
    chk(r, 32'h18);
    chk({31'h0, irq}, 32'h1);
    $display("commands done");
    @(posedge hclk);
    #1 r[0] = vpin_p;
    repeat (4) @(posedge hclk);
    #1 chk({30'h0, vpin_a, vpin_p}, {31'h0, ~r[0]});
    @(posedge hclk);
    width <= root_port_pkg::WIDTH_X2;
    train <= 1'b1;
    @(posedge hclk);
    train <= 1'b0;
    repeat (8) @(posedge hclk);
    bus(1'b0, ra[0], 32'h0);
    chk(r, 32'h2021);
    retrain <= 1'b1;
    @(posedge hclk);
    retrain <= 1'b0;
    bus(1'b0, ra[0], 32'h0);
    chk(r, 32'h2821);
    train <= 1'b1;
    @(posedge hclk);
    train <= 1'b0;
    repeat (8) @(posedge hclk);
    bus(1'b0, ra[0], 32'h0);
    chk(r, 32'h2021);
    $display("link tests done");
    give_verdict;
  end
endmodule
